// ---- ppfc_partner_model.sv ----
// Memory and link station model facing the port pins
`timescale 1ns/1ps
module ppfc_partner_model (
  // Clock and pin drive from the block
  input  wire logic       core_clk_in,
  input  wire logic [7:0] p0_in, p0_oe_in, p1_in, p1_oe_in, p2_in, p2_oe_in, p3_in, p3_oe_in,
  input  wire logic       ale_in, fetch_n_in,
  // Bench controls
  input  wire logic       cts_n_in,
  input  wire logic [7:0] p3_ext_in,
  // Resolved pin levels
  output logic      [7:0] p0_lvl_out, p1_lvl_out, p2_lvl_out, p3_lvl_out
);
  logic [7:0] mem [256];
  logic [7:0] lo_r, last_r;
  logic       rd_n, wr_n;
  //////////////////////////////////////////
  // Strobes count only while driven low
  assign rd_n = ~(p3_oe_in[7] & ~p3_in[7]);
  assign wr_n = ~(p3_oe_in[6] & ~p3_in[6]);
  // memory strobes
  // High byte ignored, so memory aliases every 256 bytes
  always @(posedge core_clk_in) begin
    if (ale_in) lo_r <= p0_in;
    if (!wr_n) mem[lo_r] <= p0_in;
    last_r <= p0_lvl_out;
  end
  // open drain bus
  // No pull-up on port zero: a floating bus shows the inverse of its last level
  assign p0_lvl_out = (p0_oe_in & p0_in) |
                      (~p0_oe_in & (!rd_n ? mem[lo_r] : !fetch_n_in ? lo_r ^ 8'h5A : ~last_r));
  assign p1_lvl_out = (p1_oe_in & p1_in) | (~p1_oe_in & {cts_n_in, 7'h7F});
  assign p2_lvl_out = (p2_oe_in & p2_in) | ~p2_oe_in;
  assign p3_lvl_out = (p3_oe_in & p3_in) | (~p3_oe_in & p3_ext_in);
endmodule // ppfc_partner_model

// ---- ppfc_pkg.sv ----
// Shared constants and types for the port pin function control block
package ppfc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Oscillator and machine cycle timing
  localparam int         OSC_PER_MC    = 12;
  localparam int         RST_HOLD_MC   = 2;
  localparam int         RST_HOLD_CYC  = RST_HOLD_MC * OSC_PER_MC;

  ////////////////////////////////////////////////////////////////////////
  // Phases within a machine cycle (each is one oscillator period)
  localparam logic [3:0] PH_FIRST      = 4'h0;
  localparam logic [3:0] PH_LAST       = 4'hB;
  localparam logic [3:0] PH_ALE_A      = 4'h0;
  localparam logic [3:0] PH_ALE_B      = 4'h6;
  localparam logic [3:0] PH_ADDR_END   = 4'h1;
  localparam logic [3:0] PH_PROG_FETCH_STROBE_ON    = 4'h2;
  localparam logic [3:0] PH_PROG_FETCH_STROBE_OFF   = 4'h4;
  localparam logic [3:0] PH_CODE_SMP   = 4'h5;
  localparam logic [3:0] PH_WDATA_ON   = 4'h2;
  localparam logic [3:0] PH_WDATA_OFF  = 4'hA;
  localparam logic [3:0] PH_XSTB_ON    = 4'h3;
  localparam logic [3:0] PH_XSTB_OFF   = 4'h9;
  localparam logic [3:0] PH_RD_SMP     = 4'hB;

  ////////////////////////////////////////////////////////////////////////
  // Address map figures
  localparam logic [15:0] INT_ROM_LIMIT   = 16'h1000;
  localparam int          SFR_SEL_BIT     = 7;

  ////////////////////////////////////////////////////////////////////////
  // Port bit positions
  localparam int P1_RTS_BIT  = 6;
  localparam int P1_CTS_BIT  = 7;
  localparam int P3_DIR_BIT  = 0;
  localparam int P3_DATA_BIT = 1;
  localparam int P3_IRQ0_BIT = 2;
  localparam int P3_IRQ1_BIT = 3;
  localparam int P3_CNT0_BIT = 4;
  localparam int P3_CNT1_BIT = 5;
  localparam int P3_WR_BIT   = 6;
  localparam int P3_RD_BIT   = 7;

  ////////////////////////////////////////////////////////////////////////
  // Link configurations and reset values
  localparam logic [1:0] LINK_MODE_PTP   = 2'h0;
  localparam logic [1:0] LINK_MODE_MULTI = 2'h1;
  localparam logic [1:0] LINK_MODE_LOOP  = 2'h2;
  localparam logic [7:0] BYTE_ZERO       = 8'h00;
  localparam logic [7:0] BYTE_ONES       = 8'hFF;
  localparam logic [32:0] PIN_SYNC_RST   = 33'h1FFFFFFFF;

  typedef enum logic {BUS_FETCH, BUS_XDATA} ppfc_bus_st_t;

endpackage : ppfc_pkg

// ---- ppfc_sync.sv ----
// Two-stage synchroniser for pins entering the oscillator domain
`timescale 1ns/1ps
module ppfc_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         sys_rst_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_r;

  ////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second; reset loads RST_VAL into both stages
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      meta_r <= RST_VAL;
      q_out  <= RST_VAL;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule // ppfc_sync

// ---- ppfc_top.sv ----
// Pin multiplexing, external bus strobes and link pin steering
`timescale 1ns/1ps
// Contract
// RQ1: port zero carries low address then data
// RQ2: port two drives high address externally
// RQ3: port1_bit6 drives request-to-send low when ready
// RQ4: station pulls port1_bit7 low when clear
// RQ5: software sets port three latch first
// RQ6: port3_bit0 gives direction, or receive data
// RQ7: port3_bit1 is link data or transmit
// RQ8: zero in transmit latch selects diagnostics
// RQ9: bits two, three: interrupts or gates
// RQ10: bits four, five: counter or link clock
// RQ11: write and read strobes on port three
// RQ12: reset held high two machine cycles
// RQ13: address latch every six periods, skip data
// RQ14: fetch strobe external only, high internal
// RQ15: select pin and 4096 limit choose fetch
// RQ16: port3_bit0 and port3_bit1 have no latch
// RQ17: link takes port one pins when invoked
// RQ18: link runs beside CPU without stalls
// RQ19: 256 byte RAM plus 128 byte registers
// RQ20: phase counter restarts at reset
module ppfc_top
  import ppfc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  // Pins in
  input  wire logic [7:0]  p0_pin_in,
  input  wire logic [7:0]  p1_pin_in,
  input  wire logic [7:0]  p2_pin_in,
  input  wire logic [7:0]  p3_pin_in,
  input  wire logic        external_fetch_select_in,
  // Pins out
  output logic      [7:0]  p0_out,
  output logic      [7:0]  p0_oe_out,
  output logic      [7:0]  p1_out,
  output logic      [7:0]  p1_oe_out,
  output logic      [7:0]  p2_out,
  output logic      [7:0]  p2_oe_out,
  output logic      [7:0]  p3_out,
  output logic      [7:0]  p3_oe_out,
  output logic             addr_latch_strobe_out,
  output logic             prog_fetch_strobe_n_out,
  // Port latches and readback
  input  wire logic [7:0]  p0_latch_in,
  input  wire logic [7:0]  p1_latch_in,
  input  wire logic [7:0]  p2_latch_in,
  input  wire logic [7:0]  p3_latch_in,
  output logic      [32:0] pins_read_out,
  // Program fetch
  input  wire logic [15:0] pc_in,
  output logic             code_valid_out,
  output logic      [7:0]  code_data_out,
  // External data access
  input  wire logic        xdata_req_in,
  input  wire logic        xdata_we_in,
  input  wire logic [15:0] xdata_addr_in,
  input  wire logic [7:0]  xdata_wdata_in,
  output logic             xdata_busy_out,
  output logic             xdata_done_out,
  output logic      [7:0]  xdata_rdata_out,
  // Serial link controller side
  input  wire logic        link_enable_in,
  input  wire logic [1:0]  link_mode_in,
  input  wire logic        link_tx_ready_in,
  input  wire logic        link_tx_en_in,
  input  wire logic        link_tx_data_in,
  input  wire logic        serial_clk_ext_in,
  output logic             link_rx_data_out,
  output logic             link_cts_out,
  output logic             link_clk_rise_out,
  output logic             diag_mode_out,
  // Interrupt and counter inputs
  output logic             ext_irq_zero_out,
  output logic             ext_irq_one_out,
  output logic             counter_zero_input_out,
  output logic             counter_one_input_out,
  // Internal data space decode
  input  wire logic [7:0]  idata_addr_in,
  input  wire logic        idata_direct_in,
  output logic             idata_ram_sel_out,
  output logic             idata_sfr_sel_out
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic [32:0] pin_s;
  logic [7:0]  p0_s, p1_s, p3_s;
  logic        ea_s;

  ppfc_sync #(.W(33), .RST_VAL(PIN_SYNC_RST)) u_sync (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .d_in        ({external_fetch_select_in, p3_pin_in, p2_pin_in, p1_pin_in, p0_pin_in}),
    .q_out       (pin_s)
  );

  // Readback comes straight off the second sync stage
  assign pins_read_out = pin_s;
  assign p0_s          = pin_s[7:0];
  assign p1_s          = pin_s[15:8];
  assign p3_s          = pin_s[31:24];
  assign ea_s          = pin_s[32];

  ////////////////////////////////////////////////////////////////////////
  // Machine cycle sequencer
  ppfc_bus_st_t bus_st_r, bus_st_nxt;
  logic [3:0]   phase_r, phase_nxt;
  logic [15:0]  fetch_addr_r, fetch_addr_nxt;
  logic         ext_fetch_r, ext_fetch_nxt;
  logic         pend_r, pend_nxt;
  logic         pend_we_r, pend_we_nxt;
  logic [15:0]  pend_addr_r, pend_addr_nxt;
  logic [7:0]   pend_wdata_r, pend_wdata_nxt;
  logic         act_we_r, act_we_nxt;
  logic [15:0]  act_addr_r, act_addr_nxt;
  logic [7:0]   act_wdata_r, act_wdata_nxt;

  // Bus owner and access kind change only at a cycle boundary
  always_comb begin
    phase_nxt      = (phase_r == PH_LAST) ? PH_FIRST : phase_r + 4'h1;
    bus_st_nxt     = bus_st_r;
    fetch_addr_nxt = fetch_addr_r;
    ext_fetch_nxt  = ext_fetch_r;
    pend_nxt       = pend_r;
    pend_we_nxt    = pend_we_r;
    pend_addr_nxt  = pend_addr_r;
    pend_wdata_nxt = pend_wdata_r;
    act_we_nxt     = act_we_r;
    act_addr_nxt   = act_addr_r;
    act_wdata_nxt  = act_wdata_r;
    // One request is held; more are refused while busy
    if (xdata_req_in && !xdata_busy_out) begin
      pend_nxt       = 1'b1;
      pend_we_nxt    = xdata_we_in;
      pend_addr_nxt  = xdata_addr_in;
      pend_wdata_nxt = xdata_wdata_in;
    end
    if (phase_r == PH_LAST) begin
      if (pend_r) begin
        bus_st_nxt    = BUS_XDATA;
        ext_fetch_nxt = 1'b0;
        act_we_nxt    = pend_we_r;
        act_addr_nxt  = pend_addr_r;
        act_wdata_nxt = pend_wdata_r;
        pend_nxt      = 1'b0;
      end else begin
        bus_st_nxt     = BUS_FETCH;
        fetch_addr_nxt = pc_in;
        // RQ15: internal below limit when select high
        ext_fetch_nxt  = !ea_s || (pc_in >= INT_ROM_LIMIT);
      end
    end
  end

  // RQ20: known phase after reset
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      bus_st_r     <= BUS_FETCH;
      phase_r      <= PH_FIRST;
      fetch_addr_r <= 16'h0000;
      ext_fetch_r  <= 1'b0;
      pend_r       <= 1'b0;
      pend_we_r    <= 1'b0;
      pend_addr_r  <= 16'h0000;
      pend_wdata_r <= BYTE_ZERO;
      act_we_r     <= 1'b0;
      act_addr_r   <= 16'h0000;
      act_wdata_r  <= BYTE_ZERO;
    end else begin
      bus_st_r     <= bus_st_nxt;
      phase_r      <= phase_nxt;
      fetch_addr_r <= fetch_addr_nxt;
      ext_fetch_r  <= ext_fetch_nxt;
      pend_r       <= pend_nxt;
      pend_we_r    <= pend_we_nxt;
      pend_addr_r  <= pend_addr_nxt;
      pend_wdata_r <= pend_wdata_nxt;
      act_we_r     <= act_we_nxt;
      act_addr_r   <= act_addr_nxt;
      act_wdata_r  <= act_wdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin and strobe output computation
  logic [7:0]  p0_nxt, p0_oe_nxt, p1_nxt, p1_oe_nxt, p2_nxt, p2_oe_nxt, p3_nxt, p3_oe_nxt;
  logic        ale_nxt, prog_fetch_strobe_n_nxt, code_valid_nxt, busy_nxt, done_nxt;
  logic [7:0]  code_data_nxt, rdata_nxt;
  logic        rx_nxt, cts_nxt, clk_lvl_nxt, clk_rise_nxt, diag_nxt;
  logic        irq0_nxt, irq1_nxt, cnt0_nxt, cnt1_nxt, ram_sel_nxt, sfr_sel_nxt;
  logic        clk_lvl_r;
  logic        bus_ext, xdata_mc, non_loop, link_own;
  logic [3:0]  ph6;
  logic [15:0] bus_addr;

  always_comb begin
    xdata_mc = (bus_st_r == BUS_XDATA);
    bus_ext  = ext_fetch_r || xdata_mc;
    ph6      = (phase_r >= PH_ALE_B) ? phase_r - PH_ALE_B : phase_r;
    bus_addr = xdata_mc ? act_addr_r : ((phase_r < PH_ALE_B) ? fetch_addr_r : fetch_addr_r + 16'h0001);
    diag_nxt = !p3_latch_in[P3_DATA_BIT];
    non_loop = (link_mode_in != LINK_MODE_LOOP) && !diag_nxt;
    // RQ17: port one pins go to the link
    link_own = link_enable_in && non_loop;
    // RQ13: address latch cadence, data cycle skips second
    ale_nxt  = (phase_r == PH_ALE_A) || ((phase_r == PH_ALE_B) && !xdata_mc);
    // RQ14: fetch strobe only on external fetch
    prog_fetch_strobe_n_nxt = !(ext_fetch_r && !xdata_mc && (ph6 >= PH_PROG_FETCH_STROBE_ON) && (ph6 <= PH_PROG_FETCH_STROBE_OFF));
    code_valid_nxt = ext_fetch_r && !xdata_mc && (ph6 == PH_CODE_SMP);
    code_data_nxt  = code_valid_nxt ? p0_s : code_data_out;
    done_nxt       = xdata_mc && (phase_r == PH_RD_SMP);
    rdata_nxt      = (done_nxt && !act_we_r) ? p0_s : xdata_rdata_out;
    busy_nxt       = pend_nxt || (bus_st_nxt == BUS_XDATA);
    // RQ1: address byte first, then data byte
    p0_nxt    = BYTE_ZERO;
    p0_oe_nxt = ~p0_latch_in;
    if (bus_ext) begin
      p0_oe_nxt = BYTE_ZERO;
      if (xdata_mc ? (phase_r <= PH_ADDR_END) : (ph6 <= PH_ADDR_END)) begin
        p0_nxt    = bus_addr[7:0];
        p0_oe_nxt = BYTE_ONES;
      end else if (xdata_mc && act_we_r && (phase_r >= PH_WDATA_ON) && (phase_r <= PH_WDATA_OFF)) begin
        p0_nxt    = act_wdata_r;
        p0_oe_nxt = BYTE_ONES;
      end
    end
    // RQ2: high address during external access, quasi port otherwise
    p2_nxt    = bus_ext ? bus_addr[15:8] : BYTE_ZERO;
    p2_oe_nxt = bus_ext ? BYTE_ONES : ~p2_latch_in;
    // Quasi ports: zero latch pulls low, pull-up gives one
    p1_nxt    = BYTE_ZERO;
    p1_oe_nxt = ~p1_latch_in;
    if (link_own) begin
      // RQ3: request-to-send pulled low while ready
      p1_oe_nxt[P1_RTS_BIT] = link_tx_ready_in;
      p1_oe_nxt[P1_CTS_BIT] = 1'b0;
    end
    p3_nxt    = BYTE_ZERO;
    p3_oe_nxt = ~p3_latch_in;
    // RQ16: no latch drive on the two link pins
    p3_oe_nxt[P3_DIR_BIT]  = 1'b0;
    p3_oe_nxt[P3_DATA_BIT] = 1'b0;
    if (link_enable_in) begin
      if (non_loop) begin
        // RQ6: direction pin follows transmit enable
        p3_nxt[P3_DIR_BIT]     = link_tx_en_in;
        p3_oe_nxt[P3_DIR_BIT]  = 1'b1;
        // RQ7: shared data line driven only when sending
        p3_nxt[P3_DATA_BIT]    = link_tx_data_in;
        p3_oe_nxt[P3_DATA_BIT] = link_tx_en_in;
      end else begin
        // RQ7: loop and diagnostics transmit on data pin
        p3_nxt[P3_DATA_BIT]    = link_tx_data_in;
        p3_oe_nxt[P3_DATA_BIT] = 1'b1;
      end
    end
    // RQ11: strobes low through the data window
    if (xdata_mc && (phase_r >= PH_XSTB_ON) && (phase_r <= PH_XSTB_OFF)) begin
      if (act_we_r) begin
        p3_oe_nxt[P3_WR_BIT] = 1'b1;
      end else begin
        p3_oe_nxt[P3_RD_BIT] = 1'b1;
      end
    end
    // RQ6: receive data from direction pin in loop modes
    rx_nxt  = non_loop ? p3_s[P3_DATA_BIT] : p3_s[P3_DIR_BIT];
    // RQ4: active-low clear from the station
    cts_nxt = link_own && !p1_s[P1_CTS_BIT];
    // RQ9: a zero latch holds the pin low and so blocks it
    irq0_nxt = p3_s[P3_IRQ0_BIT] && p3_latch_in[P3_IRQ0_BIT];
    irq1_nxt = p3_s[P3_IRQ1_BIT] && p3_latch_in[P3_IRQ1_BIT];
    // RQ10: counter one input and link clock share bit five; counter zero has bit four
    cnt0_nxt    = p3_s[P3_CNT0_BIT] && p3_latch_in[P3_CNT0_BIT];
    cnt1_nxt    = p3_s[P3_CNT1_BIT] && p3_latch_in[P3_CNT1_BIT] && !serial_clk_ext_in;
    clk_lvl_nxt = p3_s[P3_CNT1_BIT] && p3_latch_in[P3_CNT1_BIT] && serial_clk_ext_in;
    // RQ18: edge finder is free of the fetch sequencer
    clk_rise_nxt = clk_lvl_nxt && !clk_lvl_r;
    // RQ19: direct upper half selects the register space
    sfr_sel_nxt = idata_direct_in && idata_addr_in[SFR_SEL_BIT];
    ram_sel_nxt = !sfr_sel_nxt;
  end

  // RQ12: synchronous reset parks every pin
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      p0_out <= BYTE_ZERO; p0_oe_out <= BYTE_ZERO;
      p1_out <= BYTE_ZERO; p1_oe_out <= BYTE_ZERO;
      p2_out <= BYTE_ZERO; p2_oe_out <= BYTE_ZERO;
      p3_out <= BYTE_ZERO; p3_oe_out <= BYTE_ZERO;
      addr_latch_strobe_out   <= 1'b0;
      prog_fetch_strobe_n_out <= 1'b1;
      code_valid_out <= 1'b0;         code_data_out   <= BYTE_ZERO;
      xdata_busy_out <= 1'b0;         xdata_done_out  <= 1'b0;
      xdata_rdata_out <= BYTE_ZERO;   link_rx_data_out <= 1'b1;
      link_cts_out <= 1'b0;           link_clk_rise_out <= 1'b0;
      clk_lvl_r <= 1'b0;              diag_mode_out <= 1'b0;
      ext_irq_zero_out <= 1'b0;       ext_irq_one_out <= 1'b0;
      counter_zero_input_out <= 1'b0; counter_one_input_out <= 1'b0;
      idata_ram_sel_out <= 1'b1;      idata_sfr_sel_out <= 1'b0;
    end else begin
      p0_out <= p0_nxt; p0_oe_out <= p0_oe_nxt;
      p1_out <= p1_nxt; p1_oe_out <= p1_oe_nxt;
      p2_out <= p2_nxt; p2_oe_out <= p2_oe_nxt;
      p3_out <= p3_nxt; p3_oe_out <= p3_oe_nxt;
      addr_latch_strobe_out   <= ale_nxt;
      prog_fetch_strobe_n_out <= prog_fetch_strobe_n_nxt;
      code_valid_out <= code_valid_nxt; code_data_out  <= code_data_nxt;
      xdata_busy_out <= busy_nxt;     xdata_done_out  <= done_nxt;
      xdata_rdata_out <= rdata_nxt;   link_rx_data_out <= rx_nxt;
      link_cts_out <= cts_nxt;        link_clk_rise_out <= clk_rise_nxt;
      clk_lvl_r <= clk_lvl_nxt;       diag_mode_out <= diag_nxt;
      ext_irq_zero_out <= irq0_nxt;   ext_irq_one_out <= irq1_nxt;
      counter_zero_input_out <= cnt0_nxt; counter_one_input_out <= cnt1_nxt;
      idata_ram_sel_out <= ram_sel_nxt; idata_sfr_sel_out <= sfr_sel_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_phase_wrap: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RQ20
    (phase_r == PH_LAST) |=> (phase_r == PH_FIRST) ##6 (phase_r == PH_ALE_B))
    else $error("phase counter does not wrap every twelve periods");
  a_reset_park: assert property (@(posedge core_clk_in) // RQ12
    sys_rst_in |=> (phase_r == PH_FIRST) && prog_fetch_strobe_n_out && !addr_latch_strobe_out && (p0_oe_out == BYTE_ZERO))
    else $error("reset did not park strobes and port zero");
  a_ale_cadence: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RQ13
    (phase_r == 4'h1) |-> addr_latch_strobe_out ##6 (addr_latch_strobe_out == (bus_st_r == BUS_FETCH)))
    else $error("address latch strobe cadence wrong");
  a_prog_fetch_strobe_internal: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RQ14
    (!ext_fetch_r && (phase_r != PH_FIRST)) |-> prog_fetch_strobe_n_out)
    else $error("fetch strobe active without external fetch");
  a_prog_fetch_strobe_window: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RQ14
    (ext_fetch_r && (phase_r == 4'h3)) |-> !prog_fetch_strobe_n_out [*3] ##1 prog_fetch_strobe_n_out)
    else $error("fetch strobe low window wrong");
  a_fetch_select: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RQ15
    (phase_r == PH_FIRST && bus_st_r == BUS_FETCH) |-> (ext_fetch_r == (!$past(ea_s) || ($past(pc_in) >= INT_ROM_LIMIT))))
    else $error("internal or external fetch choice wrong");
  a_p0_addr_data: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RQ1
    (bus_st_r == BUS_XDATA && act_we_r && phase_r == 4'h1) |->
      (p0_oe_out == BYTE_ONES && p0_out == act_addr_r[7:0]) ##4 (p0_out == act_wdata_r))
    else $error("port zero address then data order wrong");
  a_p2_high_addr: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RQ2
    (bus_st_r == BUS_XDATA && phase_r == 4'h5) |-> (p2_oe_out == BYTE_ONES && p2_out == act_addr_r[15:8]))
    else $error("port two missing high address");
  a_wr_strobe: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RQ11
    (bus_st_r == BUS_XDATA && act_we_r && phase_r == 4'h4) |->
      (p3_oe_out[P3_WR_BIT] && !p3_oe_out[P3_RD_BIT]) [*7] ##1 !p3_oe_out[P3_WR_BIT])
    else $error("write strobe window wrong");
  a_rts_drive: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RQ3
    $past(link_own) |-> (p1_oe_out[P1_RTS_BIT] == $past(link_tx_ready_in)))
    else $error("request-to-send pin does not follow ready");
  a_dir_pin: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RQ6
    $past(link_own) |-> (p3_oe_out[P3_DIR_BIT] && p3_out[P3_DIR_BIT] == $past(link_tx_en_in)))
    else $error("direction pin does not follow transmit enable");
  a_diag_mode: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RQ8
    ##1 (diag_mode_out == !$past(p3_latch_in[P3_DATA_BIT])))
    else $error("diagnostic mode does not follow transmit latch");
  a_link_rise: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RQ18
    link_clk_rise_out |=> !link_clk_rise_out)
    else $error("link clock edge pulse longer than one cycle");

endmodule // ppfc_top

// ---- tb_ppfc_top.sv ----
// Self-checking bench for the port pin function control block
`timescale 1ns/1ps
module tb_ppfc_top;
  import ppfc_pkg::*;
  logic        core_clk_in = 0, sys_rst_in = 1, external_fetch_select_in = 1, cts_n = 1, ext_f = 0;
  logic [7:0]  p0_latch_in = '0, p1_latch_in = 8'hFF, p2_latch_in = 8'hFF, p3_latch_in = 8'hFF;
  logic [7:0]  p3_ext = 8'hFF, xdata_wdata_in = '0, idata_addr_in = '0;
  logic [15:0] pc_in = '0, xdata_addr_in = '0;
  logic        xdata_req_in = 0, xdata_we_in = 0, link_enable_in = 0, link_tx_ready_in = 0, link_tx_en_in = 0;
  logic        link_tx_data_in = 0, serial_clk_ext_in = 0, idata_direct_in = 0;
  logic [1:0]  link_mode_in = '0;
  logic [8:0]  nt;
  logic [8:0]  rd_q [$];
  wire [7:0]   p0_pin_in, p1_pin_in, p2_pin_in, p3_pin_in, p0_out, p0_oe_out, p1_out, p1_oe_out;
  wire [7:0]   p2_out, p2_oe_out, p3_out, p3_oe_out, code_data_out, xdata_rdata_out;
  wire [32:0]  pins_read_out;
  wire         addr_latch_strobe_out, prog_fetch_strobe_n_out, code_valid_out, xdata_busy_out, xdata_done_out;
  wire         link_rx_data_out, link_cts_out, link_clk_rise_out, diag_mode_out, ext_irq_zero_out;
  wire         ext_irq_one_out, counter_zero_input_out, counter_one_input_out, idata_ram_sel_out, idata_sfr_sel_out;
  int          failures = 0, cmp_count = 0, tmo = 0, seed = 32'ha79b, nale = 0, nfl = 0, nlr = 0;

  ppfc_top u_dut (.*);
  ppfc_partner_model u_mem (.core_clk_in, .p0_in(p0_out), .p0_oe_in(p0_oe_out), .p1_in(p1_out),
    .p1_oe_in(p1_oe_out), .p2_in(p2_out), .p2_oe_in(p2_oe_out), .p3_in(p3_out), .p3_oe_in(p3_oe_out),
    .ale_in(addr_latch_strobe_out), .fetch_n_in(prog_fetch_strobe_n_out), .cts_n_in(cts_n), .p3_ext_in(p3_ext),
    .p0_lvl_out(p0_pin_in), .p1_lvl_out(p1_pin_in), .p2_lvl_out(p2_pin_in), .p3_lvl_out(p3_pin_in));

  initial forever #2.5 core_clk_in = ~core_clk_in;
  //////////////////////////////////////////
  task automatic chk1(input logic got, input logic exp, input string m);
    cmp_count++;
    if (got !== exp) begin failures++; $display("BAD %0t %s", $time, m); end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin failures++; $display("BAD %0t %s", $time, m); end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n); repeat (n) @(posedge core_clk_in); endtask
  task automatic smp; @(negedge core_clk_in); endtask
  // Strobe counts over n cycles, snapshot at a rising edge
  task automatic win(input int n, output int da, output int df);
    int a0, f0;
    @(posedge core_clk_in); a0 = nale; f0 = nfl;
    cyc(n); da = nale - a0; df = nfl - f0;
  endtask
  // Reset, then count cycles to the first address strobe
  task automatic do_reset(output int off);
    sys_rst_in <= 1; cyc(RST_HOLD_CYC);
    smp; chk8(p0_oe_out | p3_oe_out, 8'h00, "reset drive"); chk1(prog_fetch_strobe_n_out, 1'b1, "reset fetch");
    @(posedge core_clk_in); sys_rst_in <= 0; off = 0;
    do begin smp; off++; end while (addr_latch_strobe_out !== 1'b1 && off < 20);
  endtask
  // One data access; a request while busy must be dropped
  task automatic xacc(input logic we, input logic [15:0] ad, input logic [7:0] wd, input logic dup);
    int k;
    @(posedge core_clk_in); xdata_req_in <= 1; xdata_we_in <= we; xdata_addr_in <= ad; xdata_wdata_in <= wd;
    rd_q.push_back({!we, wd});
    @(posedge core_clk_in); xdata_req_in <= 0;
    if (dup) begin @(posedge core_clk_in); xdata_req_in <= 1; @(posedge core_clk_in); xdata_req_in <= 0; end
    k = 0;
    do begin @(posedge core_clk_in); k++; end while (xdata_busy_out !== 1'b0 && k < 40);
    if (k >= 40) chk1(1'b0, 1'b1, "busy stuck");
  endtask
  // Watcher: takes the oldest note as each access ends
  always @(negedge core_clk_in) begin
    if (xdata_done_out === 1'b1) begin
      if (rd_q.size() == 0) chk1(1'b1, 1'b0, "extra done");
      else begin nt = rd_q.pop_front(); if (nt[8]) chk8(xdata_rdata_out, nt[7:0], "read data"); end
    end
    if (ext_f && code_valid_out === 1'b1) chk1(code_data_out === (pc_in[7:0] ^ 8'h5A) ||
      code_data_out === ((pc_in[7:0] + 8'h01) ^ 8'h5A), 1'b1, "code byte");
    if (ext_f && addr_latch_strobe_out === 1'b1) chk8(p2_out & p2_oe_out, pc_in[15:8], "high address");
    nale += addr_latch_strobe_out; nfl += !prog_fetch_strobe_n_out; nlr += link_clk_rise_out;
  end
  always @(posedge core_clk_in) if (++tmo == 5000) begin failures++; test_done; end

  initial begin
    int o1, o2, a, d;
    do_reset(o1); win(12, a, d); chk8(8'(a), 8'h02, "strobe rate");
    do_reset(o2); chk8(8'(o2), 8'(o1), "phase restart");
    $display("test reset done");
    // Internal below the limit, external at it and with select low
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk_in); external_fetch_select_in <= (i != 2); ext_f <= 0;
      pc_in <= (i == 0) ? 16'h0FFF : (i == 1) ? 16'h1000 : 16'($random(seed)) & 16'hFFFE;
      cyc(30); ext_f <= (i != 0);
      win(24, a, d); chk8(8'(a), 8'h04, "strobe count");
      chk8(8'(d), (i == 0) ? 8'h00 : 8'h0C, "fetch strobe");
    end
    @(posedge core_clk_in); ext_f <= 0; external_fetch_select_in <= 1; pc_in <= '0; cyc(30);
    $display("test fetch done");
    for (int i = 0; i < 6; i++) begin
      if (!i[0]) begin a = $random(seed); d = $random(seed); end
      xacc(!i[0], a[15:0], d[7:0], i > 3);
    end
    cyc(30); chk8(8'(rd_q.size()), 8'h00, "pending");
    $display("test xdata done");
    // Each link mode, then diagnostics by a zero transmit latch
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk_in); link_enable_in <= 1; link_mode_in <= (m == 3) ? LINK_MODE_PTP : 2'(m);
      p3_latch_in <= (m == 3) ? 8'hFD : 8'hFF; d = $random(seed); link_tx_data_in <= d[0]; p3_ext[0] <= d[1];
      link_tx_ready_in <= 1; link_tx_en_in <= 1; cts_n <= 0; cyc(5); smp;
      chk1(diag_mode_out, m == 3, "diag mode");
      chk1(p3_out[1] & p3_oe_out[1], d[0], "link data");
      if (m < 2) begin
        chk1(p1_oe_out[6] & ~p1_out[6], 1'b1, "send request"); chk1(link_cts_out, 1'b1, "clear");
        chk1(p3_oe_out[0] & p3_out[0], 1'b1, "direction"); chk1(link_rx_data_out, d[0], "rx line");
      end else begin
        chk1(p3_oe_out[0], 1'b0, "rx input"); chk1(link_rx_data_out, d[1], "rx data");
      end
    end
    @(posedge core_clk_in); link_enable_in <= 0; p3_latch_in <= 8'h00; cyc(5); smp;
    chk8(p3_oe_out, 8'hFC, "no latch drive");
    $display("test link done");
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk_in); d = $random(seed); a = $random(seed);
      p3_latch_in <= 8'(a) | 8'hC3; p3_ext <= 8'(d); cyc(5); smp;
      chk1(ext_irq_zero_out, d[2] & a[2], "irq0"); chk1(ext_irq_one_out, d[3] & a[3], "irq1");
      chk1(counter_zero_input_out, d[4] & a[4], "cnt0"); chk1(counter_one_input_out, d[5] & a[5], "cnt1");
      chk8(pins_read_out[31:24], 8'(d & (a | 8'hC3)), "readback");
    end
    @(posedge core_clk_in); p3_latch_in <= 8'hFF; p3_ext <= 8'hDF; serial_clk_ext_in <= 1; cyc(6);
    // Link clock runs only inside the burst, at an unrelated phase
    @(posedge core_clk_in); o1 = nlr; #1.3;
    repeat (16) #62.5 p3_ext[5] = ~p3_ext[5];
    cyc(6); chk8(8'(nlr - o1), 8'h08, "link clock edges");
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk_in); a = $random(seed); idata_addr_in <= 8'(a); idata_direct_in <= a[8]; cyc(3); smp;
      chk1(idata_sfr_sel_out, a[8] & a[7], "sfr sel"); chk1(idata_ram_sel_out, ~(a[8] & a[7]), "ram sel");
    end
    $display("test pins done");
    test_done;
  end
endmodule // tb_ppfc_top
